// ==== src/ccl_cfg.svh ====
// Purpose: offsets, field positions, reset values and codes of the setup word block
// Assumes: included by bare name from the two design modules
// Notes: the setup word is 24 bits; the command byte is 8 bits
`ifndef CCL_CFG_SVH
`define CCL_CFG_SVH
// command byte fields
`define CCL_CMD_CB 7
`define CCL_CMD_SC 6
`define CCL_CMD_CC 5
`define CCL_CMD_RW 4
`define CCL_CMD_RSEL_HI 3
`define CCL_CMD_RSEL_LO 1
`define CCL_CMD_PS 0
`define CCL_CMD_PUSH_READ 8'h96
// register select codes, word counts and last bit counts
`define CCL_RSEL_OFFSET 3'h0
`define CCL_RSEL_GAIN 3'h1
`define CCL_RSEL_CONFIG 3'h2
`define CCL_RSEL_DATA 3'h3
`define CCL_RSEL_SETUP 3'h4
`define CCL_SETUP_WORDS 2'h3
`define CCL_ONE_WORD 2'h1
`define CCL_CMD_LAST 5'h07
`define CCL_WORD_LAST 5'h17
// setup word fields
`define CCL_CFG_CFS 18
`define CCL_CFG_RANGE_HI 11
`define CCL_CFG_RANGE_LO 9
`define CCL_CFG_PD 8
`define CCL_CFG_RS 7
`define CCL_CFG_RV 6
`define CCL_CFG_PF 5
`define CCL_CFG_PSS 4
`define CCL_CFG_DF 3
`define CCL_CFG_CC_HI 2
`define CCL_CFG_CC_LO 0
`define CCL_CFG_WR_MASK 24'hF5FFB7
// reset values
`define CCL_CFG_RST 24'h000000
`define CCL_OFFSET_RST 24'h000000
`define CCL_GAIN_RST 24'h800000
// calibration control codes
`define CCL_CAL_NONE 3'h0
`define CCL_CAL_SELF_BOTH 3'h3
`define CCL_CAL_GAIN_LOW 2'h2
// range codes and gain factors, 8.8 fixed point
`define CCL_RANGE_100MV 3'h0
`define CCL_RANGE_55MV 3'h1
`define CCL_RANGE_25MV 3'h2
`define CCL_RANGE_1V 3'h3
`define CCL_RANGE_5V 3'h4
`define CCL_RANGE_2V5 3'h5
`define CCL_GF_100MV 16'h0140
`define CCL_GF_55MV 16'h0246
`define CCL_GF_25MV 16'h0500
`define CCL_GF_1V 16'h0280
`define CCL_GF_5V 16'h0080
`define CCL_GF_2V5 16'h0100
`define CCL_PUMP_DIV_BITS 4
`endif

// ==== src/ccl_pkg.sv ====
// Purpose: shared types of the setup word block
// Assumes: nothing
// Notes: one-hot state codes
package ccl_pkg;
  typedef enum logic [2:0] {CAL_IDLE = 3'b001, CAL_OFFSET = 3'b010, CAL_GAIN = 3'b100} ccl_cal_state_t;
  typedef enum logic [2:0] {PORT_CMD = 3'b001, PORT_WRITE = 3'b010, PORT_READ = 3'b100} ccl_port_state_t;
endpackage

// ==== src/ccl_serial_port.sv ====
// Purpose: three-wire command port: command byte, 24-bit words in and out
// Assumes: sclk, sdi and chipSel_n are synchronous to ref_clk and slow against it
// Notes: input sampled on sclk rise, output shifted on sclk fall, msb first
`timescale 1ns/1ps
`default_nettype none
`include "ccl_cfg.svh"
module ccl_serial_port (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // serial pins
  input wire logic chipSel_n,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdoOut,
  output logic sdoOe,
  // result push
  input wire logic pushReq,
  output logic pushTaken,
  // decoded traffic
  output logic cmdStrobe,
  output logic [7:0] cmdByte,
  output logic wordStrobe,
  output logic [23:0] wordData,
  output logic [1:0] wordIdx,
  output logic [1:0] rdIdx,
  output logic rdReq,
  input wire logic [23:0] rdWord
);
  ccl_pkg::ccl_port_state_t state_reg;
  logic sclkPrev_reg, needLoad_reg, cmdStrobe_reg, wordStrobe_reg;
  logic [4:0] bitCnt_reg;
  logic [23:0] rxShift_reg, txShift_reg, wordData_reg;
  logic [7:0] cmdByte_reg;
  logic [1:0] wordsLeft_reg, wordIdx_reg, strobeIdx_reg;
  wire sclkRise = sclk & ~sclkPrev_reg;
  wire sclkFall = ~sclk & sclkPrev_reg;
  wire [23:0] shiftIn = {rxShift_reg[22:0], sdi};
  wire inCmd = (state_reg == ccl_pkg::PORT_CMD);
  wire inRead = (state_reg == ccl_pkg::PORT_READ);
  wire cmdDone = inCmd && sclkRise && (bitCnt_reg == `CCL_CMD_LAST);
  wire wordDone = !inCmd && sclkRise && (bitCnt_reg == `CCL_WORD_LAST);
  wire regAccess = shiftIn[`CCL_CMD_CB] && !shiftIn[`CCL_CMD_SC] && !shiftIn[`CCL_CMD_CC] &&
                   !shiftIn[`CCL_CMD_PS] && (shiftIn[`CCL_CMD_RSEL_HI:`CCL_CMD_RSEL_LO] <= `CCL_RSEL_SETUP);
  wire [1:0] wordsNeeded = (shiftIn[`CCL_CMD_RSEL_HI:`CCL_CMD_RSEL_LO] == `CCL_RSEL_SETUP) ?
                           `CCL_SETUP_WORDS : `CCL_ONE_WORD;
  assign pushTaken = inCmd && !chipSel_n && pushReq && (bitCnt_reg == 5'h00) && !sclkRise;
  assign rdReq = inRead && needLoad_reg;
  assign sdoOut = txShift_reg[23];
  assign sdoOe = !chipSel_n && inRead;
  assign cmdStrobe = cmdStrobe_reg;
  assign cmdByte = cmdByte_reg;
  assign wordStrobe = wordStrobe_reg;
  assign wordData = wordData_reg;
  assign wordIdx = strobeIdx_reg;
  assign rdIdx = wordIdx_reg;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg <= ccl_pkg::PORT_CMD;
      sclkPrev_reg <= 1'b0;
      needLoad_reg <= 1'b0;
      cmdStrobe_reg <= 1'b0;
      wordStrobe_reg <= 1'b0;
      bitCnt_reg <= 5'h00;
      rxShift_reg <= 24'h000000;
      txShift_reg <= 24'h000000;
      wordData_reg <= 24'h000000;
      cmdByte_reg <= 8'h00;
      wordsLeft_reg <= 2'h0;
      wordIdx_reg <= 2'h0;
      strobeIdx_reg <= 2'h0;
    end else begin
      sclkPrev_reg <= sclk;
      cmdStrobe_reg <= cmdDone && !chipSel_n;
      wordStrobe_reg <= wordDone && !chipSel_n && !inRead;
      if (chipSel_n) begin
        state_reg <= ccl_pkg::PORT_CMD;
        bitCnt_reg <= 5'h00;
        needLoad_reg <= 1'b0;
      end else if (pushTaken) begin
        // continuous-read word: reuse the read path as a data register read
        state_reg <= ccl_pkg::PORT_READ;
        wordsLeft_reg <= `CCL_ONE_WORD;
        wordIdx_reg <= 2'h0;
        needLoad_reg <= 1'b1;
        cmdByte_reg <= `CCL_CMD_PUSH_READ;
      end else begin
        if (rdReq) begin
          txShift_reg <= rdWord;
          needLoad_reg <= 1'b0;
        end else if (sclkFall && inRead && (bitCnt_reg != 5'h00)) begin
          txShift_reg <= {txShift_reg[22:0], 1'b0};
        end
        if (sclkRise) begin
          rxShift_reg <= shiftIn;
          bitCnt_reg <= 5'(bitCnt_reg + 5'h01);
          if (cmdDone) begin
            bitCnt_reg <= 5'h00;
            cmdByte_reg <= shiftIn[7:0];
            wordIdx_reg <= 2'h0;
            wordsLeft_reg <= wordsNeeded;
            needLoad_reg <= regAccess && shiftIn[`CCL_CMD_RW];
            if (regAccess) begin
              state_reg <= shiftIn[`CCL_CMD_RW] ? ccl_pkg::PORT_READ : ccl_pkg::PORT_WRITE;
            end
          end else if (wordDone) begin
            bitCnt_reg <= 5'h00;
            wordData_reg <= shiftIn;
            strobeIdx_reg <= wordIdx_reg;
            wordIdx_reg <= 2'(wordIdx_reg + 2'h1);
            if (wordsLeft_reg == `CCL_ONE_WORD) begin
              state_reg <= ccl_pkg::PORT_CMD;
            end else begin
              wordsLeft_reg <= 2'(wordsLeft_reg - 2'h1);
              needLoad_reg <= inRead;
            end
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== src/ccl_config_low.sv ====
// Purpose: lower setup word fields of a delta-sigma converter behind its serial port
// Assumes: convCycleDone pulses once per conversion cycle from the modulator
// Notes: upper setup bits other than CFS (drives chopFast) and bits 19 and 17 (masked to zero on write) are stored and read back only
`timescale 1ns/1ps
`default_nettype none
`include "ccl_cfg.svh"
module ccl_config_low (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // serial command port
  input wire logic chipSel_n,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdoOut,
  output logic sdoOe,
  // modulator side
  input wire logic convCycleDone,
  input wire logic [23:0] convData,
  // charge pump
  output logic pumpDriveOut,
  output logic pumpDriveOe,
  // analog front end
  output logic ampEngaged,
  output logic ampBypass,
  output logic rangeValid,
  output logic [15:0] gainFactor,
  output logic chopFast,
  // power, reset, port flag, conversion and calibration
  output logic oscRun,
  output logic powerSaveActive,
  output logic portFlagMode,
  output logic softResetActive,
  output logic convRunning,
  output logic calOffsetStep,
  output logic calGainStep,
  output logic calSystem
);
  logic cmdStrobe, wordStrobe, rdReq, pushTaken;
  logic [7:0] cmdByte;
  logic [23:0] wordData, rdWord, cfgWord;
  logic [1:0] wordIdx, rdIdx;
  logic [23:0] cfg_reg, cfg_next, offset_reg, gain_reg, data_reg;
  logic rvFlag_reg, dfFlag_reg, ps_reg, cont_reg, single_reg, convPend_reg;
  logic [17:0] rangeInfo_reg;
  logic [`CCL_PUMP_DIV_BITS-1:0] pumpCnt_reg;
  ccl_pkg::ccl_cal_state_t calState_reg, calState_next;

  function automatic logic [2:0] regSel(input logic [2:0] rsel, input logic [1:0] idx);
    return (rsel == `CCL_RSEL_SETUP) ? {1'b0, idx} : rsel;
  endfunction

  // valid, amplifier engaged, gain factor
  function automatic logic [17:0] rangeDecode(input logic [2:0] code);
    unique case (code)
      `CCL_RANGE_100MV: return {2'b11, `CCL_GF_100MV};
      `CCL_RANGE_55MV: return {2'b11, `CCL_GF_55MV};
      `CCL_RANGE_25MV: return {2'b11, `CCL_GF_25MV};
      `CCL_RANGE_1V: return {2'b10, `CCL_GF_1V};
      `CCL_RANGE_5V: return {2'b10, `CCL_GF_5V};
      `CCL_RANGE_2V5: return {2'b10, `CCL_GF_2V5};
      default: return 18'h00000;
    endcase
  endfunction

  ccl_serial_port u_port (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .chipSel_n(chipSel_n),
    .sclk(sclk),
    .sdi(sdi),
    .sdoOut(sdoOut),
    .sdoOe(sdoOe),
    .pushReq(convPend_reg),
    .pushTaken(pushTaken),
    .cmdStrobe(cmdStrobe),
    .cmdByte(cmdByte),
    .wordStrobe(wordStrobe),
    .wordData(wordData),
    .wordIdx(wordIdx),
    .rdIdx(rdIdx),
    .rdReq(rdReq),
    .rdWord(rdWord)
  );

  wire [2:0] rsel = cmdByte[`CCL_CMD_RSEL_HI:`CCL_CMD_RSEL_LO];
  wire [2:0] wrSel = regSel(rsel, wordIdx);
  wire [2:0] rdSel = regSel(rsel, rdIdx);
  wire cfgWrite = wordStrobe && (wrSel == `CCL_RSEL_CONFIG);
  wire rsHeld = cfg_reg[`CCL_CFG_RS];
  wire rsEnter = cfgWrite && !rsHeld && wordData[`CCL_CFG_RS];
  wire rsFall = cfgWrite && rsHeld && !wordData[`CCL_CFG_RS];
  wire cmdExec = cmdStrobe && cmdByte[`CCL_CMD_CB];
  wire psCmd = cmdExec && cmdByte[`CCL_CMD_PS];
  wire [2:0] calCode = cfg_reg[`CCL_CFG_CC_HI:`CCL_CFG_CC_LO];
  wire [2:0] newCode = wordData[`CCL_CFG_CC_HI:`CCL_CFG_CC_LO];
  wire calCodeOk = (newCode[1:0] != 2'h0) && !(newCode[2] && (newCode[1:0] == 2'h3));
  wire calStart = cfgWrite && !rsHeld && !wordData[`CCL_CFG_RS] && calCodeOk;
  wire calIdle = (calState_reg == ccl_pkg::CAL_IDLE);
  wire calStepEnd = convCycleDone && !calIdle;
  wire calFinal = calStepEnd && ((calState_reg == ccl_pkg::CAL_GAIN) || (calCode != `CCL_CAL_SELF_BOTH));
  wire convEvt = convCycleDone && calIdle && (cont_reg || single_reg) && !ps_reg;
  wire dfSet = calFinal || convEvt;
  wire dfClr = rdReq && ((rdSel == `CCL_RSEL_OFFSET) || (rdSel == `CCL_RSEL_GAIN) || (rdSel == `CCL_RSEL_DATA));
  wire rvClr = rdReq && (rdSel == `CCL_RSEL_CONFIG);
  wire pushSet = convEvt && cfg_reg[`CCL_CFG_PF] && cont_reg;

  assign cfgWord = cfg_reg | (24'(rvFlag_reg) << `CCL_CFG_RV) | (24'(dfFlag_reg) << `CCL_CFG_DF);
  assign rdWord = (rdSel == `CCL_RSEL_OFFSET) ? offset_reg :
                  (rdSel == `CCL_RSEL_GAIN) ? gain_reg :
                  (rdSel == `CCL_RSEL_CONFIG) ? cfgWord :
                  (rdSel == `CCL_RSEL_DATA) ? data_reg : 24'h000000;

  always_comb begin
    cfg_next = cfg_reg;
    if (cfgWrite) begin
      if (rsHeld) begin
        cfg_next = rsFall ? `CCL_CFG_RST : cfg_reg;
      end else if (wordData[`CCL_CFG_RS]) begin
        cfg_next = `CCL_CFG_RST | (24'h000001 << `CCL_CFG_RS);
      end else begin
        cfg_next = wordData & `CCL_CFG_WR_MASK;
      end
    end else if (calFinal) begin
      cfg_next[`CCL_CFG_CC_HI:`CCL_CFG_CC_LO] = `CCL_CAL_NONE;
    end
  end

  always_comb begin
    calState_next = calState_reg;
    if (rsHeld || rsEnter) begin
      calState_next = ccl_pkg::CAL_IDLE;
    end else if (cfgWrite) begin
      if (!calStart) begin
        calState_next = ccl_pkg::CAL_IDLE;
      end else if (newCode[1:0] == `CCL_CAL_GAIN_LOW) begin
        calState_next = ccl_pkg::CAL_GAIN;
      end else begin
        calState_next = ccl_pkg::CAL_OFFSET;
      end
    end else if (calStepEnd) begin
      if ((calState_reg == ccl_pkg::CAL_OFFSET) && (calCode == `CCL_CAL_SELF_BOTH)) begin
        calState_next = ccl_pkg::CAL_GAIN;
      end else begin
        calState_next = ccl_pkg::CAL_IDLE;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cfg_reg <= `CCL_CFG_RST;
      offset_reg <= `CCL_OFFSET_RST;
      gain_reg <= `CCL_GAIN_RST;
      data_reg <= 24'h000000;
      rvFlag_reg <= 1'b0;
      dfFlag_reg <= 1'b0;
      ps_reg <= 1'b0;
      cont_reg <= 1'b0;
      single_reg <= 1'b0;
      convPend_reg <= 1'b0;
      rangeInfo_reg <= rangeDecode(`CCL_RANGE_100MV);
      pumpCnt_reg <= '0;
      calState_reg <= ccl_pkg::CAL_IDLE;
    end else begin
      cfg_reg <= cfg_next;
      calState_reg <= calState_next;
      rangeInfo_reg <= rangeDecode(cfg_next[`CCL_CFG_RANGE_HI:`CCL_CFG_RANGE_LO]);
      pumpCnt_reg <= pumpCnt_reg + 1'b1;
      rvFlag_reg <= rsFall || (rvFlag_reg && !rvClr);
      dfFlag_reg <= !rsHeld && (dfSet || (dfFlag_reg && !dfClr));
      convPend_reg <= !rsHeld && (pushSet || (convPend_reg && !pushTaken));
      if (convEvt) begin
        data_reg <= convData;
      end
      if (rsEnter) begin
        offset_reg <= `CCL_OFFSET_RST;
        gain_reg <= `CCL_GAIN_RST;
      end else if (wordStrobe && !rsHeld && (wrSel == `CCL_RSEL_OFFSET)) begin
        offset_reg <= wordData;
      end else if (wordStrobe && !rsHeld && (wrSel == `CCL_RSEL_GAIN)) begin
        gain_reg <= wordData;
      end
      if (rsHeld || rsEnter) begin
        ps_reg <= 1'b0;
        cont_reg <= 1'b0;
        single_reg <= 1'b0;
      end else if (cmdExec) begin
        ps_reg <= psCmd;
        cont_reg <= !psCmd && cmdByte[`CCL_CMD_CC];
        single_reg <= !psCmd && cmdByte[`CCL_CMD_SC];
      end else if (convEvt) begin
        single_reg <= 1'b0;
      end
    end
  end

  assign pumpDriveOut = pumpCnt_reg[`CCL_PUMP_DIV_BITS-1];
  assign pumpDriveOe = !cfg_reg[`CCL_CFG_PD] && !ps_reg;
  assign rangeValid = rangeInfo_reg[17];
  assign ampEngaged = rangeInfo_reg[17] && rangeInfo_reg[16];
  assign ampBypass = rangeInfo_reg[17] && !rangeInfo_reg[16];
  assign gainFactor = rangeInfo_reg[15:0];
  assign chopFast = cfg_reg[`CCL_CFG_CFS];
  assign oscRun = !(ps_reg && cfg_reg[`CCL_CFG_PSS]);
  assign powerSaveActive = ps_reg;
  assign portFlagMode = cfg_reg[`CCL_CFG_PF];
  assign softResetActive = rsHeld;
  assign convRunning = cont_reg || single_reg;
  assign calOffsetStep = (calState_reg == ccl_pkg::CAL_OFFSET);
  assign calGainStep = (calState_reg == ccl_pkg::CAL_GAIN);
  assign calSystem = !calIdle && calCode[2];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence calLastStep;
    convCycleDone && (calState_reg == ccl_pkg::CAL_GAIN) && !cfgWrite;
  endsequence
  sequence calPairFirst;
    convCycleDone && calOffsetStep && (calCode == `CCL_CAL_SELF_BOTH) && !cfgWrite;
  endsequence

  chk_pump_disable: assert property (cfgWrite && !rsHeld && !wordData[`CCL_CFG_RS] && wordData[`CCL_CFG_PD]
    |=> !pumpDriveOe) else $error("pump drive not floated");
  chk_pump_save: assert property (psCmd && !rsHeld |=> !pumpDriveOe [*2])
    else $error("pump drive active in power save");
  chk_reset_valid: assert property (rsFall |=> rvFlag_reg && !rsHeld)
    else $error("reset valid not set after reset cycle");
  chk_rv_read: assert property (rvClr && !rsFall |=> !rvFlag_reg)
    else $error("reset valid not cleared by read");
  chk_pf_stream: assert property (pushSet |=> convPend_reg ##[0:2] pushTaken || chipSel_n)
    else $error("port flag result not pushed");
  chk_sleep_osc: assert property (ps_reg && cfg_reg[`CCL_CFG_PSS] |-> !oscRun ##1 (!oscRun || !ps_reg))
    else $error("oscillator running in sleep");
  chk_cal_done: assert property (calLastStep |=> dfFlag_reg && (calCode == `CCL_CAL_NONE) && calIdle)
    else $error("calibration end not flagged");
  chk_cal_pair: assert property (calPairFirst |=> calGainStep && !$rose(dfFlag_reg) && (calCode == `CCL_CAL_SELF_BOTH))
    else $error("combined calibration skipped gain step");
  chk_df_clear: assert property (dfClr && !dfSet && !rsHeld |=> !dfFlag_reg)
    else $error("done flag not cleared by read");
  chk_amp_route: assert property ($changed(cfg_reg[`CCL_CFG_RANGE_HI:`CCL_CFG_RANGE_LO])
    && (cfg_reg[`CCL_CFG_RANGE_HI:`CCL_CFG_RANGE_LO] <= `CCL_RANGE_25MV) |-> ampEngaged && !ampBypass)
    else $error("low range not through amplifier");
  chk_reset_zero: assert property ($past(sys_rst) |-> (cfgWord == 24'h000000) && calIdle)
    else $error("fields not zero after reset");
endmodule
`default_nettype wire

// ==== dv/ccl_host_model.sv ====
// Purpose: host side of the three-wire command port, driving frames and reading data out
// Assumes: sclk high and low 4 ref_clk cycles each, above the 2-cycle minimum
// Notes: data out is read just before each sclk rise; a released line shows the inverse of its last value
`timescale 1ns/1ps
`default_nettype none
module ccl_host_model (
  // clock
  input wire logic ref_clk,
  // serial pins
  output logic chipSel_n,
  output logic sclk,
  output logic sdi,
  input wire logic sdoOut,
  input wire logic sdoOe
);
  logic sdoLast = 1'b0;
  logic sdoWire;

  assign sdoWire = sdoOe ? sdoOut : ~sdoLast;

  initial begin
    chipSel_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end

  always @(posedge ref_clk) begin
    if (sdoOe)
      sdoLast <= sdoOut;
  end

  // msb first, n bits of v out, n bits of data out back
  task automatic shift(input logic [23:0] v, input int n, output logic [23:0] r);
    r = 24'h000000;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = v[i];
      sclk = 1'b0;
      repeat (4) @(posedge ref_clk);
      #1;
      r[i] = sdoWire;
      sclk = 1'b1;
      repeat (4) @(posedge ref_clk);
      #1;
    end
    sclk = 1'b0;
  endtask

  // one frame: command byte, then one data word when hasData is set
  task automatic access(input logic [7:0] cmd, input logic [23:0] wr, input logic hasData,
                        output logic [23:0] rd);
    logic [23:0] unused;
    @(posedge ref_clk);
    #1;
    chipSel_n = 1'b0;
    shift({16'h0000, cmd}, 8, unused);
    rd = 24'h000000;
    if (hasData)
      shift(wr, 24, rd);
    repeat (4) @(posedge ref_clk);
    #1;
    chipSel_n = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask

  // select the port with no command and clock out a pushed result
  task automatic pushed(output logic [23:0] rd);
    @(posedge ref_clk);
    #1;
    chipSel_n = 1'b0;
    repeat (8) @(posedge ref_clk);
    #1;
    shift(24'h000000, 24, rd);
    repeat (4) @(posedge ref_clk);
    #1;
    chipSel_n = 1'b1;
  endtask
endmodule
`default_nettype wire

// ==== dv/test_ccl_config_low.sv ====
// Purpose: self-checking bench for the lower setup word fields
// Assumes: host model frames; modulator pulses driven here
// Notes: every frame ends with the port deselected
`timescale 1ns/1ps
`default_nettype none
module test_ccl_config_low;
  localparam int CycleLimit = 40000;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic convCycleDone = 1'b0;
  logic [23:0] convData = 24'h000000;
  logic chipSel_n, sclk, sdi, sdoOut, sdoOe, pumpDriveOut, pumpDriveOe, ampEngaged, ampBypass, rangeValid;
  logic chopFast, oscRun, powerSaveActive, portFlagMode, softResetActive, convRunning;
  logic calOffsetStep, calGainStep, calSystem;
  logic [15:0] gainFactor;
  logic [23:0] rd;
  logic [2:0] c;
  logic pd0;
  logic [15:0] gfTab [8] = '{16'h0140, 16'h0246, 16'h0500, 16'h0280, 16'h0080, 16'h0100, 16'h0000, 16'h0000};
  logic [2:0] calTab [4] = '{3'h1, 3'h2, 3'h5, 3'h6};
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;

  always #2.5 ref_clk = ~ref_clk;

  ccl_host_model host (.ref_clk(ref_clk), .chipSel_n(chipSel_n), .sclk(sclk), .sdi(sdi), .sdoOut(sdoOut),
    .sdoOe(sdoOe));

  ccl_config_low DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .chipSel_n(chipSel_n), .sclk(sclk), .sdi(sdi),
    .sdoOut(sdoOut), .sdoOe(sdoOe), .convCycleDone(convCycleDone), .convData(convData),
    .pumpDriveOut(pumpDriveOut), .pumpDriveOe(pumpDriveOe), .ampEngaged(ampEngaged), .ampBypass(ampBypass),
    .rangeValid(rangeValid), .gainFactor(gainFactor), .chopFast(chopFast), .oscRun(oscRun),
    .powerSaveActive(powerSaveActive), .portFlagMode(portFlagMode), .softResetActive(softResetActive),
    .convRunning(convRunning), .calOffsetStep(calOffsetStep), .calGainStep(calGainStep), .calSystem(calSystem));

  task automatic chkWord(input string name, input logic [23:0] exp, input logic [23:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chkPin(input string name, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wrCfg(input logic [23:0] v);
    logic [23:0] d;
    host.access(8'h84, v, 1'b1, d);
  endtask

  task automatic rdCfg(input logic [23:0] e);
    logic [23:0] d;
    host.access(8'h94, 24'h000000, 1'b1, d);
    chkWord("setup word", e, d);
  endtask

  // one modulator cycle end carrying a result
  task automatic pulse(input logic [23:0] v);
    @(posedge ref_clk);
    #1;
    convData = v;
    convCycleDone = 1'b1;
    @(posedge ref_clk);
    #1;
    convCycleDone = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == CycleLimit) begin
      mismatches++;
      stop_test();
    end
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chkPin("pump drive enable", 1'b1, pumpDriveOe);
    pd0 = pumpDriveOut;
    // pump square wave flips every 8 cycles
    repeat (8) @(posedge ref_clk);
    #1;
    chkPin("pump drive toggle", !pd0, pumpDriveOut);
    chkPin("oscillator", 1'b1, oscRun);
    chkPin("data out enable", 1'b0, sdoOe);
    rdCfg(24'h000000);
    for (int r = 0; r < 8; r++) begin
      wrCfg(24'(r) << 9);
      chkPin("amp engaged", r < 3, ampEngaged);
      chkPin("amp bypass", r >= 3 && r < 6, ampBypass);
      chkPin("range valid", r < 6, rangeValid);
      chkWord("gain factor", {8'h00, gfTab[r]}, {8'h00, gainFactor});
    end
    wrCfg(24'h000100);
    chkPin("pump drive enable", 1'b0, pumpDriveOe);
    rdCfg(24'h000100);
    wrCfg(24'h000000);
    chkPin("pump drive enable", 1'b1, pumpDriveOe);
    wrCfg(24'h040020);
    chkPin("fast chop", 1'b1, chopFast);
    chkPin("port flag", 1'b1, portFlagMode);
    rdCfg(24'h040020);
    wrCfg(24'h000000);
    chkPin("port flag", 1'b0, portFlagMode);
    wrCfg(24'h000080);
    chkPin("soft reset", 1'b1, softResetActive);
    wrCfg(24'h000180);
    rdCfg(24'h000080);
    wrCfg(24'h000000);
    chkPin("soft reset", 1'b0, softResetActive);
    rdCfg(24'h000040);
    rdCfg(24'h000000);
    for (int p = 0; p < 2; p++) begin
      wrCfg(24'(p) << 4);
      host.access(8'h81, 24'h000000, 1'b0, rd);
      chkPin("power save", 1'b1, powerSaveActive);
      chkPin("oscillator", p == 0, oscRun);
      chkPin("pump drive enable", 1'b0, pumpDriveOe);
      host.access(8'h94, 24'h000000, 1'b1, rd);
      chkWord("setup word", 24'(p) << 4, rd);
      chkPin("oscillator", 1'b1, oscRun);
      chkPin("pump drive enable", 1'b1, pumpDriveOe);
    end
    wrCfg(24'h000000);
    for (int i = 0; i < 4; i++) begin
      c = calTab[i];
      wrCfg({21'h000000, c});
      chkPin("offset step", !c[1], calOffsetStep);
      chkPin("gain step", c[1], calGainStep);
      chkPin("system cal", c[2], calSystem);
      pulse(24'h000000);
      rdCfg(24'h000008);
      rdCfg(24'h000008);
      host.access(8'h90, 24'h000000, 1'b1, rd);
      rdCfg(24'h000000);
    end
    wrCfg(24'h000003);
    chkPin("offset step", 1'b1, calOffsetStep);
    pulse(24'h000000);
    chkPin("gain step", 1'b1, calGainStep);
    rdCfg(24'h000003);
    pulse(24'h000000);
    rdCfg(24'h000008);
    host.access(8'h92, 24'h000000, 1'b1, rd);
    rdCfg(24'h000000);
    for (int i = 0; i < 2; i++) begin
      c = i ? 3'h7 : 3'h4;
      wrCfg({21'h000000, c});
      chkPin("offset step", 1'b0, calOffsetStep);
      chkPin("gain step", 1'b0, calGainStep);
      rdCfg({21'h000000, c});
    end
    wrCfg(24'h000000);
    host.access(8'hC0, 24'h000000, 1'b0, rd);
    chkPin("conversion", 1'b1, convRunning);
    pulse(24'h5A5A5A);
    rdCfg(24'h000008);
    host.access(8'h96, 24'h000000, 1'b1, rd);
    chkWord("data word", 24'h5A5A5A, rd);
    rdCfg(24'h000000);
    wrCfg(24'h000020);
    host.access(8'hA0, 24'h000000, 1'b0, rd);
    pulse(24'hC3A5F0);
    host.pushed(rd);
    chkWord("pushed word", 24'hC3A5F0, rd);
    stop_test();
  end
endmodule
`default_nettype wire
